// file: prog_exc_pkg.sv
// Constants, codes and register map of the program exception level
package prog_exc_pkg;

  typedef logic [7:0]  code_t;
  typedef logic [63:0] status_word_t;

  // Status word positions, position p is bit p of the 64-bit word
  localparam int unsigned PX_POS   = 0;
  localparam int unsigned MC_POS   = 1;
  localparam int unsigned PS_POS   = 19;
  localparam int unsigned PM_B_POS = 36;
  localparam int unsigned PM_D_POS = 37;
  localparam int unsigned PM_E_POS = 38;
  localparam int unsigned PM_S_POS = 39;

  // Low nibbles of the program exception codes
  localparam logic [3:0] CODE_NONE    = 4'h0;
  localparam logic [3:0] CODE_OPER    = 4'h1;
  localparam logic [3:0] CODE_PRIV    = 4'h2;
  localparam logic [3:0] CODE_EXEC    = 4'h3;
  localparam logic [3:0] CODE_PROT    = 4'h4;
  localparam logic [3:0] CODE_ADDR    = 4'h5;
  localparam logic [3:0] CODE_SPEC    = 4'h6;
  localparam logic [3:0] CODE_DATA    = 4'h7;
  localparam logic [3:0] CODE_FXOVF   = 4'h8;
  localparam logic [3:0] CODE_FXDIV   = 4'h9;
  localparam logic [3:0] CODE_DECOVF  = 4'ha;
  localparam logic [3:0] CODE_DECDIV  = 4'hb;
  localparam logic [3:0] CODE_EXPOVF  = 4'hc;
  localparam logic [3:0] CODE_EXPUNF  = 4'hd;
  localparam logic [3:0] CODE_SIGNIF  = 4'he;
  localparam int unsigned NUM_CAUSES  = 14;

  localparam logic [2:0] PE_PREFIX    = 3'h0;
  localparam logic [2:0] MC_PREFIX    = 3'h7;
  localparam logic [3:0] MC_PE_LOW    = 4'hc;

  // Floating-point registers that may be named
  localparam logic [3:0] FP_REG_MAX   = 4'h6;

  // Register byte offsets
  localparam logic [7:0] OFS_SW_LOW   = 8'h00;
  localparam logic [7:0] OFS_SW_HIGH  = 8'h04;
  localparam logic [7:0] OFS_CTRL     = 8'h08;
  localparam logic [7:0] OFS_LAST     = 8'h0c;
  localparam logic [7:0] OFS_COUNT    = 8'h10;

  // Values after reset
  localparam logic [31:0] RST_SW_LOW  = 32'h0000_0000;
  localparam logic [31:0] RST_SW_HIGH = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
  localparam code_t       RST_CODE    = 8'h00;

  // Control register field
  localparam int unsigned CTRL_COMPAT_POS = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : prog_exc_pkg

// file: exc_priority.sv
// Fixed-priority selection of one exception code from the cause lines
`timescale 1ns/1ns
module exc_priority #(
  parameter int unsigned N = 14
) (
  input  logic [N-1:0] causes,
  output logic [3:0]   code,
  output logic         any
);
  import prog_exc_pkg::*;

  // Four code bits leave room for fifteen causes beside the empty code
  if (N < 1 || N > 15) begin : g_bad_n
    $error("exc_priority: N must be 1 to 15");
  end

  // Lowest code wins; only one code fits in the interrupt word
  function automatic logic [3:0] first_set(input logic [N-1:0] v);
    logic [3:0] r;
    r = CODE_NONE;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i + 1);
      end
    end
    return r;
  endfunction : first_set

  assign code = first_set(causes); // [RULE24]
  assign any  = |causes;

endmodule : exc_priority

// file: program_exception_level.sv
// Program exception level: detection, masking, escalation and codes
//
// Summary of operation
// [RULE1] A detected misuse raises a request and suppresses or terminates.
// [RULE2] Exception entry sequence only when status word bit 0 is one.
// [RULE3] Maskable types also need their program mask bit, bits 36 to 39.
// [RULE4] With bit 0 clear a machine check is raised; the cause is dropped.
// [RULE5] Program mask bit zero: processing goes on with nothing raised.
// [RULE6] Mask one: enable to exception, else machine check, else fatal.
// [RULE7] Code 1 for illegal operation or extended ops in compat mode.
// [RULE8] Code 2 for a privileged operation in problem state, bit 19.
// [RULE9] Code 3 when an execute targets another execute.
// [RULE10] Code 4 for a storage protection violation.
// [RULE11] Code 5 for out-of-range address or control store load fault.
// [RULE12] Code 6 for alignment, odd pair, decimal length, key address.
// [RULE13] Code 6 also for a floating register not 0, 2, 4 or 6.
// [RULE14] Code 7 for bad decimal data, overlap, zeros, missing sign.
// [RULE15] Code 8 for fixed overflow, gated by bit 36.
// [RULE16] Code 9 for fixed divide overflow or convert beyond 31 bits.
// [RULE17] Code 0xa for decimal overflow, gated by bit 37.
// [RULE18] Code 0xb for decimal divide quotient overflow.
// [RULE19] Code 0xc for exponent overflow, never mask gated.
// [RULE20] Code 0xd for exponent underflow, gated by bit 38.
// [RULE21] Flag bit of each code: zero suppressed, one terminated.
// [RULE22] Code 0xe for zero fraction from add or subtract, gated bit 39.
// [RULE23] Escalated machine check reports code 111T 1100.
// [RULE24] Several causes at once yield one code by fixed priority.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module program_exception_level (
  input  logic                   aclk,
  input  logic                   aresetn,
  // AXI4-Lite slave
  input  logic [7:0]             s_axi_awaddr,
  input  logic                   s_axi_awvalid,
  output logic                   s_axi_awready,
  input  logic [31:0]            s_axi_wdata,
  input  logic [3:0]             s_axi_wstrb,
  input  logic                   s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  logic                   s_axi_bready,
  input  logic [7:0]             s_axi_araddr,
  input  logic                   s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  logic                   s_axi_rready,
  // Detection lines from the execution unit
  input  logic                   exc_valid,
  input  logic                   exc_terminate,
  input  logic [13:0]            cause_in,
  input  logic                   ext_instr,
  input  logic                   pair_used,
  input  logic                   pair_reg_odd,
  input  logic                   fp_reg_used,
  input  logic [3:0]             fp_reg_num,
  // Outcome
  output logic                   suppress_instr,
  output logic                   terminate_instr,
  output logic                   pe_entry,
  output logic                   mc_entry,
  output logic                   nonrecoverable,
  output prog_exc_pkg::code_t    int_code,
  output prog_exc_pkg::code_t    mc_code
);
  import prog_exc_pkg::*;

  logic [31:0]  sw_low;
  logic [31:0]  sw_high;
  logic [31:0]  ctrl;
  code_t        last_pe_code;
  logic [2:0]   last_outcome;
  logic [31:0]  event_count;
  logic [7:0]   aw_addr;
  logic         aw_full;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         w_full;

  status_word_t sw;
  logic         px;
  logic         mc_en;
  logic         ps;
  logic         compat;
  logic [13:0]  raw;
  logic [13:0]  gated;
  logic [3:0]   sel_code;
  logic         sel_any;
  logic         fp_bad;
  logic         take;
  logic         masked_off;
  logic         do_write;
  logic         wr_sw_low;
  logic         wr_sw_high;
  logic         wr_ctrl;
  logic         wr_ok;
  logic         rd_ok;
  logic [31:0]  rd_value;
  logic [31:0]  last_word;

  assign sw     = {sw_high, sw_low};
  assign px     = sw[PX_POS];
  assign mc_en  = sw[MC_POS];
  assign ps     = sw[PS_POS];
  assign compat = ctrl[CTRL_COMPAT_POS];

  // Byte-lane merge shared by both status word registers; ctrl takes bit 0 from lane 0 only
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Cause lines, one per code, index is code minus one
  assign fp_bad = fp_reg_used & (fp_reg_num[0] | (fp_reg_num > FP_REG_MAX));
  assign raw[0]  = cause_in[0] | (ext_instr & compat); // [RULE7]
  assign raw[1]  = cause_in[1] & ps; // [RULE8]
  assign raw[2]  = cause_in[2]; // [RULE9]
  assign raw[3]  = cause_in[3]; // [RULE10]
  assign raw[4]  = cause_in[4]; // [RULE11]
  assign raw[5]  = cause_in[5] | (pair_used & pair_reg_odd) | fp_bad; // [RULE12] [RULE13]
  assign raw[6]  = cause_in[6]; // [RULE14]
  assign raw[7]  = cause_in[7]; // [RULE15]
  assign raw[8]  = cause_in[8]; // [RULE16]
  assign raw[9]  = cause_in[9]; // [RULE17]
  assign raw[10] = cause_in[10]; // [RULE18]
  assign raw[11] = cause_in[11]; // [RULE19]
  assign raw[12] = cause_in[12]; // [RULE20]
  assign raw[13] = cause_in[13]; // [RULE22]

  // Masked types drop out before priority, so an unmasked one still wins
  assign gated[6:0]   = raw[6:0];
  assign gated[7]     = raw[7] & sw[PM_B_POS]; // [RULE3] [RULE15]
  assign gated[8]     = raw[8];
  assign gated[9]     = raw[9] & sw[PM_D_POS]; // [RULE3] [RULE17]
  assign gated[11:10] = raw[11:10]; // [RULE19]
  assign gated[12]    = raw[12] & sw[PM_E_POS]; // [RULE3] [RULE20]
  assign gated[13]    = raw[13] & sw[PM_S_POS]; // [RULE3] [RULE22]

  exc_priority #(
    .N      (NUM_CAUSES)
  ) u_prio (
    .causes (gated),
    .code   (sel_code),
    .any    (sel_any)
  );

  assign take       = exc_valid & sel_any; // [RULE1]
  assign masked_off = exc_valid & (|raw) & ~sel_any; // [RULE5]

  // Outcome pulses, one cycle after the detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      suppress_instr  <= 1'b0;
      terminate_instr <= 1'b0;
      pe_entry        <= 1'b0;
      mc_entry        <= 1'b0;
      nonrecoverable  <= 1'b0;
    end else begin
      suppress_instr  <= take & ~exc_terminate; // [RULE1]
      terminate_instr <= take & exc_terminate; // [RULE1]
      pe_entry        <= take & px; // [RULE2] [RULE6]
      mc_entry        <= take & ~px & mc_en; // [RULE4] [RULE6]
      nonrecoverable  <= take & ~px & ~mc_en; // [RULE6]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_code <= RST_CODE;
      mc_code  <= RST_CODE;
    end else if (take & px) begin
      int_code <= {PE_PREFIX, exc_terminate, sel_code}; // [RULE21] [RULE24]
    end else if (take & mc_en) begin
      mc_code  <= {MC_PREFIX, exc_terminate, MC_PE_LOW}; // [RULE23]
    end
  end

  // Escalation keeps no trace of the original cause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_pe_code <= RST_CODE;
      last_outcome <= 3'h0;
      event_count  <= 32'h0000_0000;
    end else if (take) begin
      last_pe_code <= px ? {PE_PREFIX, exc_terminate, sel_code}
                         : RST_CODE; // [RULE4]
      last_outcome <= {~px & ~mc_en, ~px & mc_en, px};
      event_count  <= event_count + 32'h0000_0001;
    end
  end

  // Write channel: address and data taken in either order
  assign do_write   = aw_full & w_full & ~s_axi_bvalid;
  assign wr_sw_low  = aw_addr == OFS_SW_LOW;
  assign wr_sw_high = aw_addr == OFS_SW_HIGH;
  assign wr_ctrl    = aw_addr == OFS_CTRL;
  assign wr_ok      = wr_sw_low | wr_sw_high | wr_ctrl;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_full       <= 1'b0;
      aw_addr       <= 8'h00;
    end else if (s_axi_awvalid & s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_full       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~aw_full & ~s_axi_bvalid;
      aw_full       <= aw_full & ~do_write;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_full       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
    end else if (s_axi_wvalid & s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_full       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else begin
      s_axi_wready <= s_axi_wvalid & ~w_full & ~s_axi_bvalid;
      w_full       <= w_full & ~do_write;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_low  <= RST_SW_LOW;
      sw_high <= RST_SW_HIGH;
      ctrl    <= RST_CTRL;
    end else if (do_write) begin
      if (wr_sw_low) begin
        sw_low <= merge(sw_low, w_data, w_strb);
      end
      if (wr_sw_high) begin
        sw_high <= merge(sw_high, w_data, w_strb);
      end
      if (wr_ctrl) begin
        ctrl <= {31'h0, (w_strb[0] ? w_data[0] : ctrl[0])};
      end
    end
  end

  // Read channel
  assign last_word = {13'h0000, last_outcome, mc_code, last_pe_code};
  assign rd_ok     = (s_axi_araddr == OFS_SW_LOW) |
                     (s_axi_araddr == OFS_SW_HIGH) |
                     (s_axi_araddr == OFS_CTRL) |
                     (s_axi_araddr == OFS_LAST) |
                     (s_axi_araddr == OFS_COUNT);
  assign rd_value  = (s_axi_araddr == OFS_SW_LOW)  ? sw_low :
                     (s_axi_araddr == OFS_SW_HIGH) ? sw_high :
                     (s_axi_araddr == OFS_CTRL)    ? ctrl :
                     (s_axi_araddr == OFS_LAST)    ? last_word :
                     (s_axi_araddr == OFS_COUNT)   ? event_count :
                     32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_escalate;
    take && !px && mc_en;
  endsequence

  sequence s_mc_out;
    mc_entry && !pe_entry && !nonrecoverable;
  endsequence

  a_request_disposes: assert property ( // [RULE1]
    take |=> (suppress_instr ^ terminate_instr))
    else $error("Detected exception did not dispose instruction");

  a_entry_needs_px: assert property ( // [RULE2]
    pe_entry |-> $past(px) && !mc_entry && !nonrecoverable)
    else $error("Exception entry without enable bit");

  a_mask_gates_code: assert property ( // [RULE3]
    pe_entry && int_code[3:0] == CODE_FXOVF |-> $past(sw[PM_B_POS]))
    else $error("Fixed overflow taken with mask clear");

  a_escalate_mc: assert property ( // [RULE4]
    s_escalate |=> s_mc_out)
    else $error("Escalation to machine check missing");

  a_masked_quiet: assert property ( // [RULE5]
    masked_off |=> !suppress_instr && !terminate_instr && !pe_entry
                   && !mc_entry && !nonrecoverable)
    else $error("Masked exception produced an outcome");

  a_nonrecov_case: assert property ( // [RULE6]
    take && !px && !mc_en |=> nonrecoverable && !mc_entry)
    else $error("Nonrecoverable error not declared");

  a_priv_problem: assert property ( // [RULE8]
    pe_entry && int_code[3:0] == CODE_PRIV |-> $past(ps))
    else $error("Privileged code outside problem state");

  a_flag_bit: assert property ( // [RULE21]
    pe_entry |-> int_code[4] == $past(exc_terminate)
                 && int_code[4] == terminate_instr)
    else $error("Suppress flag in code wrong");

  a_mc_code_val: assert property ( // [RULE23]
    mc_entry |-> mc_code[7:5] == MC_PREFIX && mc_code[3:0] == MC_PE_LOW)
    else $error("Machine check code wrong");

  a_write_answer: assert property (
    do_write |=> s_axi_bvalid)
    else $error("Write response missing");

  a_resp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write response dropped before bready");

endmodule : program_exception_level

// file: test_program_exception_level.sv
// Self-checking testbench of the program exception level
`timescale 1ns/1ns
module test_program_exception_level;
  import prog_exc_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        exc_valid;
  logic        exc_terminate;
  logic [13:0] cause_in;
  logic        ext_instr;
  logic        pair_used;
  logic        pair_reg_odd;
  logic        fp_reg_used;
  logic [3:0]  fp_reg_num;
  logic        suppress_instr;
  logic        terminate_instr;
  logic        pe_entry;
  logic        mc_entry;
  logic        nonrecoverable;
  code_t       int_code;
  code_t       mc_code;
  code_t       int_exp;
  code_t       mc_exp;
  int          fails;
  int          total_checks;

  program_exception_level u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .exc_valid(exc_valid),
    .exc_terminate(exc_terminate), .cause_in(cause_in),
    .ext_instr(ext_instr), .pair_used(pair_used),
    .pair_reg_odd(pair_reg_odd), .fp_reg_used(fp_reg_used),
    .fp_reg_num(fp_reg_num), .suppress_instr(suppress_instr),
    .terminate_instr(terminate_instr), .pe_entry(pe_entry),
    .mc_entry(mc_entry), .nonrecoverable(nonrecoverable),
    .int_code(int_code), .mc_code(mc_code));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Bus waits are bounded so a dead slave ends the run instead of hanging
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 50) begin fails++; conclude(); end
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata; r = rresp;
    rready <= 1'b0;
    if (n == 50) begin fails++; conclude(); end
  endtask : axr

  task automatic sw(input logic [31:0] lo, input logic [31:0] hi);
    logic [1:0] r;
    axw(OFS_SW_LOW, lo, r);
    chk("sw_low resp", r, RESP_OKAY);
    axw(OFS_SW_HIGH, hi, r);
    chk("sw_high resp", r, RESP_OKAY);
  endtask : sw

  // One detection event; o is the outcome {nonrecoverable, mc, pe}
  task automatic ev(input logic [13:0] c, input logic t,
                    input logic [7:0] sd, input logic [2:0] o,
                    input logic [3:0] nib);
    @(posedge aclk);
    exc_valid <= 1'b1; exc_terminate <= t; cause_in <= c;
    {ext_instr, pair_used, pair_reg_odd, fp_reg_used, fp_reg_num} <= sd;
    @(posedge aclk);
    exc_valid <= 1'b0; cause_in <= '0;
    {ext_instr, pair_used, pair_reg_odd, fp_reg_used, fp_reg_num} <= '0;
    #1;
    if (o[0]) int_exp = {PE_PREFIX, t, nib};
    if (o[1]) mc_exp = {MC_PREFIX, t, MC_PE_LOW};
    chk("pe_entry", pe_entry, o[0]);
    chk("mc_entry", mc_entry, o[1]);
    chk("nonrecoverable", nonrecoverable, o[2]);
    chk("suppress_instr", suppress_instr, (|o) & ~t);
    chk("terminate_instr", terminate_instr, (|o) & t);
    chk("int_code", int_code, int_exp);
    chk("mc_code", mc_code, mc_exp);
  endtask : ev

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 5; i++) begin
      axr(8'(i * 4), d, r);
      chk("reset value", d, 32'h0000_0000);
    end
    axr(8'h14, d, r);
    chk("unmapped read resp", r, RESP_SLVERR);
    chk("unmapped read data", d, 32'h0000_0000);
    axw(OFS_LAST, 32'hffff_ffff, r);
    chk("read-only write resp", r, RESP_SLVERR);
    axw(OFS_CTRL, 32'hffff_ffff, r);
    axr(OFS_CTRL, d, r);
    chk("ctrl keeps bit0", d, 32'h0000_0001);
    axw(OFS_CTRL, 32'h0000_0000, r);
    wstrb <= 4'h2;
    axw(OFS_SW_HIGH, 32'hffff_ffff, r);
    wstrb <= 4'hf;
    axr(OFS_SW_HIGH, d, r);
    chk("byte lane write", d, 32'h0000_ff00);
    $display("register test done");
  endtask : t_regs

  // Every code with all masks open, flag alternating
  task automatic t_codes;
    logic [31:0] d;
    logic [1:0]  r;
    sw(32'h0008_0001, 32'h0000_00f0);
    for (int i = 1; i <= 14; i++) begin
      ev(14'(1 << (i - 1)), i[0], 8'h00, 3'b001, 4'(i));
    end
    axr(OFS_COUNT, d, r);
    chk("count", d, 32'd14);
    $display("code test done");
  endtask : t_codes

  task automatic t_masks;
    sw(32'h0008_0001, 32'h0000_0000);
    ev(14'h0080, 1'b0, 8'h00, 3'b000, 4'h0);
    ev(14'h0200, 1'b0, 8'h00, 3'b000, 4'h0);
    ev(14'h1000, 1'b1, 8'h00, 3'b000, 4'h0);
    ev(14'h2000, 1'b0, 8'h00, 3'b000, 4'h0);
    ev(14'h0100, 1'b0, 8'h00, 3'b001, 4'h9);
    ev(14'h0400, 1'b1, 8'h00, 3'b001, 4'hb);
    ev(14'h0800, 1'b0, 8'h00, 3'b001, 4'hc);
    ev(14'h0480, 1'b0, 8'h00, 3'b001, 4'hb);
    sw(32'h0008_0001, 32'h0000_00f0);
    ev(14'h0088, 1'b1, 8'h00, 3'b001, 4'h4);
    ev(14'h3fff, 1'b0, 8'h00, 3'b001, 4'h1);
    $display("mask test done");
  endtask : t_masks

  task automatic t_special;
    logic [1:0] r;
    sw(32'h0000_0001, 32'h0000_00f0);
    ev(14'h0002, 1'b0, 8'h00, 3'b000, 4'h0);
    ev(14'h0000, 1'b0, 8'h80, 3'b000, 4'h0);
    axw(OFS_CTRL, 32'h0000_0001, r);
    ev(14'h0000, 1'b1, 8'h80, 3'b001, 4'h1);
    axw(OFS_CTRL, 32'h0000_0000, r);
    ev(14'h0000, 1'b0, 8'h60, 3'b001, 4'h6);
    ev(14'h0000, 1'b0, 8'h40, 3'b000, 4'h0);
    ev(14'h0000, 1'b1, 8'h13, 3'b001, 4'h6);
    ev(14'h0000, 1'b0, 8'h14, 3'b000, 4'h0);
    ev(14'h0000, 1'b0, 8'h17, 3'b001, 4'h6);
    ev(14'h0000, 1'b1, 8'h18, 3'b001, 4'h6);
    $display("special test done");
  endtask : t_special

  // Enable clear: cause lost, machine check or fatal instead
  task automatic t_escalate;
    logic [31:0] d;
    logic [1:0]  r;
    sw(32'h0000_0002, 32'h0000_00f0);
    ev(14'h0008, 1'b1, 8'h00, 3'b010, 4'h0);
    ev(14'h0010, 1'b0, 8'h00, 3'b010, 4'h0);
    sw(32'h0000_0002, 32'h0000_0000);
    ev(14'h0080, 1'b0, 8'h00, 3'b000, 4'h0);
    sw(32'h0000_0000, 32'h0000_00f0);
    ev(14'h0008, 1'b1, 8'h00, 3'b100, 4'h0);
    axr(OFS_LAST, d, r);
    chk("cause dropped", d, 32'h0004_ec00);
    sw(32'h0000_0001, 32'h0000_0000);
    ev(14'h2000, 1'b0, 8'h00, 3'b000, 4'h0);
    $display("escalation test done");
  endtask : t_escalate

  initial begin
    fails = 0; total_checks = 0;
    int_exp = RST_CODE; mc_exp = RST_CODE;
    aresetn = 1'b0; awaddr = '0; awvalid = 1'b0; wdata = '0;
    wstrb = 4'hf;
    wvalid = 1'b0; bready = 1'b0; araddr = '0; arvalid = 1'b0;
    rready = 1'b0; exc_valid = 1'b0; exc_terminate = 1'b0;
    cause_in = '0; ext_instr = 1'b0; pair_used = 1'b0;
    pair_reg_odd = 1'b0; fp_reg_used = 1'b0; fp_reg_num = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_codes();
    t_masks();
    t_special();
    t_escalate();
    conclude();
  end
endmodule : test_program_exception_level
